/* File: verilog/ucil_pkg.sv */
// Constants and carrier types for the UART channel interrupt logic.
// ==================================================================
// What this block does
// - FIFO mode: receive interrupt and code follow level versus trigger.
// - Data ready bit sets on character stored, clears when FIFO empties.
// - Line status: overrun, head errors, holding, all empty, any error.
// - Mask bit 0 gates receive data interrupt; resets to zero.
// - Mask bit 1 gates transmit interrupt; resets to zero.
// - Mask bit 2 raises line status interrupt on bits 1 to 4.
// - Mask bit 3 raises modem interrupt on any delta bit.
// - Mask bit 4 reserved; bits 5-7 need enhanced bit 4.
// - Flow input rising edge raises pin change under auto input control.
// - Flow output rising edge raises pin change under auto output mode.
// - Status read returns six-bit code of the held source, else the highest pending.
// - Reported source stays reported until serviced and cleared.
// - Timeout after four characters plus twelve bits below trigger.
// - Transmit source from trigger or empty; transmitter empty in RS-485 with FIFO mode on.
// - Xon, Xoff or special character detection raises an interrupt.
// - Pending state also shown on the global channel indication.
// - Status bit 0 low while pending, high when none.
// - Fixed six-bit codes for each of the seven sources.
// - Each source clears by its own read or write action.
package ucil_pkg;

  // ================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_HOLDING = 4'h0;
  localparam logic [3:0] IDX_MASK = 4'h1;
  localparam logic [3:0] IDX_SOURCE = 4'h2;
  localparam logic [3:0] IDX_MODEM_CTL = 4'h4;
  localparam logic [3:0] IDX_LINE = 4'h5;
  localparam logic [3:0] IDX_MODEM_ST = 4'h6;
  localparam logic [3:0] IDX_ENH = 4'h9;
  localparam logic [3:0] IDX_RX_LEVEL = 4'hb;
  localparam logic [3:0] IDX_FLOW_CHAR = 4'hc;
  localparam logic [3:0] IDX_STOP_TWO = 4'hd;
  localparam logic [3:0] IDX_RESUME_ONE = 4'he;
  localparam logic [3:0] IDX_RESUME_TWO = 4'hf;

  // ================================================================
  // Field positions.
  localparam int MASK_RX = 0;
  localparam int MASK_TX = 1;
  localparam int MASK_LINE = 2;
  localparam int MASK_MODEM = 3;
  localparam int MASK_FLOW_CHAR_DETECT = 5;
  localparam int MASK_RTS = 6;
  localparam int MASK_CTS = 7;
  localparam int ENH_GATE = 4;
  localparam int ENH_AUTO_RTS = 6;
  localparam int ENH_AUTO_CTS = 7;
  localparam int MCR_FLOW_SEL = 2;
  localparam int FCR_FIFO_EN = 0;

  // ================================================================
  // Reset values and timing counts.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_RX_TRIG = 8'h01;
  localparam logic [7:0] TO_CHARS = 8'h04;
  localparam logic [7:0] TO_EXTRA_BITS = 8'h0c;

  // ================================================================
  // Sources in priority order and their status codes.
  localparam logic [2:0] SRC_LINE = 3'h0;
  localparam logic [2:0] SRC_RX = 3'h1;
  localparam logic [2:0] SRC_TIMEOUT = 3'h2;
  localparam logic [2:0] SRC_TX = 3'h3;
  localparam logic [2:0] SRC_MODEM = 3'h4;
  localparam logic [2:0] SRC_FLOW_CHAR_DETECT = 3'h5;
  localparam logic [2:0] SRC_FLOW = 3'h6;
  localparam logic [2:0] SRC_NONE = 3'h7;
  localparam logic [5:0] CODE_LINE = 6'h06;
  localparam logic [5:0] CODE_RX = 6'h04;
  localparam logic [5:0] CODE_TIMEOUT = 6'h0c;
  localparam logic [5:0] CODE_TX = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_FLOW_CHAR_DETECT = 6'h10;
  localparam logic [5:0] CODE_FLOW = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;

  // ================================================================
  // Carrier types.
  typedef struct packed {
    logic [7:0] level;
    logic char_stored;
    logic fifo_empty;
    logic overrun;
    logic [2:0] head_err;
    logic any_err;
    logic [7:0] data;
    logic bit_tick;
    logic [3:0] char_bits;
    logic xon_det;
    logic xoff_det;
    logic spec_det;
  } ucil_rx_s;

  typedef struct packed {
    logic holding_empty;
    logic all_empty;
    logic below_trig;
    logic fifo_empty;
    logic rs485_auto;
  } ucil_tx_s;

  typedef struct packed {
    logic [3:0] status;
    logic [3:0] delta_evt;
    logic rts_level;
    logic dtr_level;
  } ucil_modem_s;

  typedef struct packed {
    logic fifo_en;
    logic [7:0] rx_trigger_level;
    logic [7:0] stop_char_one;
    logic [7:0] stop_char_two;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] modem_control;
    logic [7:0] enhanced_function;
  } ucil_cfg_s;

  typedef struct packed {
    logic rx_pop;
    logic tx_push;
    logic [7:0] tx_data;
  } ucil_strobe_s;

endpackage

/* File: verilog/ucil_channel.sv */
// Per-channel interrupt logic with its APB register slave.
`timescale 1ns/1ps
module ucil_channel
  import ucil_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ucil_rx_s rx_i,
  input wire ucil_tx_s tx_i,
  input wire ucil_modem_s modem_i,
  input wire logic cts_pin,
  input wire logic dsr_pin,
  output ucil_cfg_s cfg_o,
  output ucil_strobe_s strobe_o,
  output logic irq_o,
  output logic irq_oe_n,
  output logic [7:0] global_channel_irq_status
);

  // ================================================================
  // State registers.
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  ucil_cfg_s cfg_reg, cfg_next;
  ucil_strobe_s strobe_reg, strobe_next;
  logic [7:0] interrupt_mask_reg, interrupt_mask_next;
  logic data_ready_reg, data_ready_next;
  logic overrun_reg, overrun_next;
  logic line_pend_reg, line_pend_next;
  logic to_pend_reg, to_pend_next;
  logic [7:0] to_cnt_reg, to_cnt_next;
  logic tx_pend_reg, tx_pend_next;
  logic tx_cond_reg;
  logic [3:0] delta_reg, delta_next;
  logic flow_char_detect_pend_reg, flow_char_detect_pend_next;
  logic [1:0] flow_char_detect_reg, flow_char_detect_next;
  logic cts_chg_reg, cts_chg_next;
  logic rts_chg_reg, rts_chg_next;
  logic [1:0] cts_sync_reg, dsr_sync_reg;
  logic flow_in_prev_reg, flow_out_prev_reg;
  logic [2:0] cur_src_reg, cur_src_next;
  logic [5:0] code_reg;
  logic irq_oe_n_reg;
  logic [7:0] global_reg;

  // ================================================================
  // Address decode and access strobes.
  logic [3:0] idx;
  logic mapped;
  logic acc_setup, acc_done, rd_acc, wr_acc;
  logic rd_holding, rd_source, rd_line, rd_modem, rd_flow_char;
  logic wr_holding;
  logic [7:0] rd_value;

  assign idx = paddr[5:2];
  assign acc_setup = psel & ~penable;
  assign acc_done = psel & penable & pready_reg;
  assign rd_acc = acc_done & ~pwrite & mapped;
  assign wr_acc = acc_done & pwrite & mapped;
  assign rd_holding = rd_acc & (idx == IDX_HOLDING);
  assign rd_source = rd_acc & (idx == IDX_SOURCE);
  assign rd_line = rd_acc & (idx == IDX_LINE);
  assign rd_modem = rd_acc & (idx == IDX_MODEM_ST);
  assign rd_flow_char = rd_acc & (idx == IDX_FLOW_CHAR);
  assign wr_holding = wr_acc & (idx == IDX_HOLDING);

  // Only word-aligned addresses of implemented indices answer cleanly.
  always_comb
  begin
    mapped = 1'b0;
    if (paddr[1:0] != 2'b00 || paddr[7:6] != 2'b00)
      mapped = 1'b0;
    else if (idx == IDX_HOLDING || idx == IDX_MASK || idx == IDX_SOURCE)
      mapped = 1'b1;
    else if (idx == IDX_MODEM_CTL || idx == IDX_LINE)
      mapped = 1'b1;
    else if (idx == IDX_MODEM_ST || idx == IDX_ENH)
      mapped = 1'b1;
    else if (idx >= IDX_RX_LEVEL)
      mapped = 1'b1;
  end

  // ================================================================
  // Flow pin synchronisers; the pins are asynchronous to pclk.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cts_sync_reg <= 2'b00;
      dsr_sync_reg <= 2'b00;
    end
    else
    begin
      cts_sync_reg <= {cts_sync_reg[0], cts_pin};
      dsr_sync_reg <= {dsr_sync_reg[0], dsr_pin};
    end
  end

  // ================================================================
  // Source conditions.
  logic fifo_en, gate;
  logic rx_ready, to_arm, to_fire, tx_cond;
  logic flow_in, flow_out, flow_in_rise, flow_out_rise;
  logic [7:0] to_limit;
  logic [6:0] pend_vec;

  assign fifo_en = cfg_reg.fifo_en;
  assign gate = cfg_reg.enhanced_function[ENH_GATE];
  // In FIFO mode a level compare against the trigger, following the FIFO both ways; otherwise the data ready bit.
  assign rx_ready = fifo_en ? (rx_i.level >= cfg_reg.rx_trigger_level)
                            : data_ready_reg;
  // Timeout only counts while data sits below the trigger.
  assign to_arm = fifo_en & ~rx_i.fifo_empty &
                  (rx_i.level < cfg_reg.rx_trigger_level);
  assign to_limit = 8'(TO_CHARS * {4'h0, rx_i.char_bits}) + TO_EXTRA_BITS;
  assign to_fire = to_arm & rx_i.bit_tick &
                   (to_cnt_reg == to_limit - 8'h01);
  // In FIFO mode auto RS-485 waits for the shifter too, so the line turns round late.
  assign tx_cond = ~fifo_en ? tx_i.holding_empty :
                   tx_i.rs485_auto ? tx_i.all_empty :
                   (tx_i.below_trig | tx_i.fifo_empty);
  assign flow_in = cfg_reg.modem_control[MCR_FLOW_SEL] ? dsr_sync_reg[1]
                                                       : cts_sync_reg[1];
  assign flow_out = cfg_reg.modem_control[MCR_FLOW_SEL] ? modem_i.dtr_level
                                                        : modem_i.rts_level;
  assign flow_in_rise = flow_in & ~flow_in_prev_reg &
                        cfg_reg.enhanced_function[ENH_AUTO_CTS];
  assign flow_out_rise = flow_out & ~flow_out_prev_reg &
                         cfg_reg.enhanced_function[ENH_AUTO_RTS];

  // Masked pending vector, index equals priority.
  assign pend_vec[SRC_LINE] = line_pend_reg &
                              interrupt_mask_reg[MASK_LINE];
  assign pend_vec[SRC_RX] = rx_ready &
                            interrupt_mask_reg[MASK_RX];
  assign pend_vec[SRC_TIMEOUT] = to_pend_reg & interrupt_mask_reg[MASK_RX];
  assign pend_vec[SRC_TX] = tx_pend_reg &
                            interrupt_mask_reg[MASK_TX];
  assign pend_vec[SRC_MODEM] = (|delta_reg) &
                               interrupt_mask_reg[MASK_MODEM];
  assign pend_vec[SRC_FLOW_CHAR_DETECT] = flow_char_detect_pend_reg & gate &
                               interrupt_mask_reg[MASK_FLOW_CHAR_DETECT];
  assign pend_vec[SRC_FLOW] = gate &
    ((cts_chg_reg & interrupt_mask_reg[MASK_CTS]) |
     (rts_chg_reg & interrupt_mask_reg[MASK_RTS]));

  // Status code for a source index.
  function automatic logic [5:0] src_code(input logic [2:0] src);
    logic [5:0] c;
    c = CODE_NONE;
    case (src)
      SRC_LINE: c = CODE_LINE;
      SRC_RX: c = CODE_RX;
      SRC_TIMEOUT: c = CODE_TIMEOUT;
      SRC_TX: c = CODE_TX;
      SRC_MODEM: c = CODE_MODEM;
      SRC_FLOW_CHAR_DETECT: c = CODE_FLOW_CHAR_DETECT;
      SRC_FLOW: c = CODE_FLOW;
      default: c = CODE_NONE;
    endcase
    return c;
  endfunction

  // ================================================================
  // Read data mux; write-only offsets read as zero.
  always_comb
  begin
    rd_value = RST_ZERO;
    if (idx == IDX_HOLDING)
      rd_value = rx_i.data;
    else if (idx == IDX_MASK)
      rd_value = interrupt_mask_reg;
    else if (idx == IDX_SOURCE)
      rd_value = {fifo_en, fifo_en, code_reg};
    else if (idx == IDX_MODEM_CTL)
      rd_value = cfg_reg.modem_control;
    else if (idx == IDX_LINE)
      rd_value = {rx_i.any_err, tx_i.all_empty, tx_i.holding_empty,
                  rx_i.head_err, overrun_reg, data_ready_reg};
    else if (idx == IDX_MODEM_ST)
      rd_value = {modem_i.status, delta_reg};
    else if (idx == IDX_ENH)
      rd_value = cfg_reg.enhanced_function;
    else if (idx == IDX_RX_LEVEL)
      rd_value = rx_i.level;
    else if (idx == IDX_FLOW_CHAR)
      rd_value = {6'h00, flow_char_detect_reg};
  end

  // ================================================================
  // Bus and configuration next state. Every access gets exactly one
  // access cycle, so the master never waits longer than that.
  always_comb
  begin
    pready_next = acc_setup;
    prdata_next = acc_setup ? {24'h000000, rd_value} : prdata_reg;
    pslverr_next = acc_setup ? ~mapped : pslverr_reg;
    cfg_next = cfg_reg;
    interrupt_mask_next = interrupt_mask_reg;
    strobe_next.rx_pop = rd_holding;
    strobe_next.tx_push = wr_holding;
    strobe_next.tx_data = wr_holding ? pwdata[7:0] : strobe_reg.tx_data;
    if (wr_acc)
    begin
      if (idx == IDX_MASK)
      begin
        // Upper mask bits hold unless the enhanced gate is open.
        interrupt_mask_next[3:0] = pwdata[3:0];
        interrupt_mask_next[4] = 1'b0;
        if (gate)
          interrupt_mask_next[7:5] = pwdata[7:5];
      end
      else if (idx == IDX_SOURCE)
        cfg_next.fifo_en = pwdata[FCR_FIFO_EN];
      else if (idx == IDX_MODEM_CTL)
        cfg_next.modem_control = pwdata[7:0];
      else if (idx == IDX_ENH)
        cfg_next.enhanced_function = pwdata[7:0];
      else if (idx == IDX_RX_LEVEL)
        cfg_next.rx_trigger_level = pwdata[7:0];
      else if (idx == IDX_FLOW_CHAR)
        cfg_next.stop_char_one = pwdata[7:0];
      else if (idx == IDX_STOP_TWO)
        cfg_next.stop_char_two = pwdata[7:0];
      else if (idx == IDX_RESUME_ONE)
        cfg_next.resume_char_one = pwdata[7:0];
      else if (idx == IDX_RESUME_TWO)
        cfg_next.resume_char_two = pwdata[7:0];
    end
  end

  // ================================================================
  // Interrupt next state. In every sticky flag the set term is applied
  // after the clear, so an event in the clearing cycle is kept.
  always_comb
  begin
    data_ready_next = data_ready_reg;
    if (rx_i.fifo_empty)
      data_ready_next = 1'b0;
    if (rx_i.char_stored)
      data_ready_next = 1'b1;
    overrun_next = (overrun_reg & ~rd_line) | rx_i.overrun;
    line_pend_next = (line_pend_reg & ~rd_line) | rx_i.overrun |
      (rx_i.char_stored & (|rx_i.head_err));
    to_cnt_next = to_cnt_reg;
    if (rx_i.char_stored | rd_holding | ~to_arm)
      to_cnt_next = 8'h00;
    else if (rx_i.bit_tick & (to_cnt_reg < to_limit))
      to_cnt_next = to_cnt_reg + 8'h01;
    to_pend_next = (to_pend_reg & ~rd_holding) | to_fire;
    tx_pend_next = (tx_pend_reg & ~wr_holding &
                    ~(rd_source & (cur_src_reg == SRC_TX))) |
                   (tx_cond & ~tx_cond_reg);
    delta_next = (delta_reg & {4{~rd_modem}}) | modem_i.delta_evt;
    flow_char_detect_pend_next = (flow_char_detect_pend_reg & ~rd_source) | rx_i.xon_det |
                      rx_i.xoff_det | rx_i.spec_det;
    flow_char_detect_next = (flow_char_detect_reg & {2{~rd_flow_char}}) |
                            {rx_i.xon_det, rx_i.xoff_det};
    cts_chg_next = (cts_chg_reg & ~rd_modem) | flow_in_rise;
    rts_chg_next = (rts_chg_reg & ~rd_modem) | flow_out_rise;
    // Keep the reported source while it pends; else take the highest.
    cur_src_next = SRC_NONE;
    if (cur_src_reg != SRC_NONE && pend_vec[cur_src_reg])
      cur_src_next = cur_src_reg;
    else
      for (int i = 6; i >= 0; i--)
        if (pend_vec[i])
          cur_src_next = 3'(i);
  end

  // ================================================================
  // Registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      cfg_reg <= '{fifo_en: 1'b0, rx_trigger_level: RST_RX_TRIG,
                   default: RST_ZERO};
      strobe_reg <= '0;
      interrupt_mask_reg <= RST_ZERO;
      data_ready_reg <= 1'b0;
      overrun_reg <= 1'b0;
      line_pend_reg <= 1'b0;
      to_pend_reg <= 1'b0;
      to_cnt_reg <= 8'h00;
      tx_pend_reg <= 1'b0;
      tx_cond_reg <= 1'b0;
      delta_reg <= 4'h0;
      flow_char_detect_pend_reg <= 1'b0;
      flow_char_detect_reg <= 2'b00;
      cts_chg_reg <= 1'b0;
      rts_chg_reg <= 1'b0;
      flow_in_prev_reg <= 1'b0;
      flow_out_prev_reg <= 1'b0;
      cur_src_reg <= SRC_NONE;
      code_reg <= CODE_NONE;
      irq_oe_n_reg <= 1'b1;
      global_reg <= {2'b00, CODE_NONE};
    end
    else
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      cfg_reg <= cfg_next;
      strobe_reg <= strobe_next;
      interrupt_mask_reg <= interrupt_mask_next;
      data_ready_reg <= data_ready_next;
      overrun_reg <= overrun_next;
      line_pend_reg <= line_pend_next;
      to_pend_reg <= to_pend_next;
      to_cnt_reg <= to_cnt_next;
      tx_pend_reg <= tx_pend_next;
      tx_cond_reg <= tx_cond;
      delta_reg <= delta_next;
      flow_char_detect_pend_reg <= flow_char_detect_pend_next;
      flow_char_detect_reg <= flow_char_detect_next;
      cts_chg_reg <= cts_chg_next;
      rts_chg_reg <= rts_chg_next;
      flow_in_prev_reg <= flow_in;
      flow_out_prev_reg <= flow_out;
      cur_src_reg <= cur_src_next;
      code_reg <= src_code(cur_src_next);
      irq_oe_n_reg <= ~(|pend_vec);
      global_reg <= {1'b0, |pend_vec, src_code(cur_src_next)};
    end
  end

  // Outputs straight from flops; the open-drain pin only ever pulls low.
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cfg_o = cfg_reg;
  assign strobe_o = strobe_reg;
  assign irq_o = 1'b0 & irq_oe_n_reg;
  assign irq_oe_n = irq_oe_n_reg;
  assign global_channel_irq_status = global_reg;

  // ================================================================
  // Assertions.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RX_ONLY_CODE: assert property (
    (pend_vec == 7'b0000010) && (cur_src_reg == SRC_NONE)
    |=> (code_reg == CODE_RX))
    else $error("receive source alone did not report its code");
  AST_READY_SET: assert property (
    rx_i.char_stored |=> data_ready_reg)
    else $error("data ready not set after a stored character");
  AST_READY_CLR: assert property (
    rx_i.fifo_empty && !rx_i.char_stored |=> !data_ready_reg)
    else $error("data ready not cleared on empty FIFO");
  AST_MASK_LOCK: assert property (
    wr_acc && (idx == IDX_MASK) && !gate
    |=> $stable(interrupt_mask_reg[7:5]))
    else $error("upper mask bits changed with the gate closed");
  AST_HOLD_SRC: assert property (
    (cur_src_reg != SRC_NONE) && pend_vec[cur_src_reg]
    |=> $stable(cur_src_reg))
    else $error("reported source changed while still pending");
  AST_IDLE_BIT: assert property (
    code_reg[0] == irq_oe_n_reg)
    else $error("status bit 0 disagrees with the request pin");
  AST_TIMEOUT: assert property (
    to_fire |=> to_pend_reg)
    else $error("timeout expiry did not raise the timeout flag");
  AST_MODEM_IRQ: assert property (
    (modem_i.delta_evt != 4'h0) && interrupt_mask_reg[MASK_MODEM] && !wr_acc
    |=> ##1 !irq_oe_n)
    else $error("modem delta did not reach the request pin");
  AST_FLOW_IN: assert property (
    flow_in_rise |=> cts_chg_reg)
    else $error("flow input rise not captured");
  AST_LINE_CLR: assert property (
    rd_line && !rx_i.overrun && !rx_i.char_stored |=> !line_pend_reg)
    else $error("line status read did not clear its source");

endmodule // ucil_channel

/* File: test/ucil_host_model.sv */
// Host processor model: APB master for the channel registers.
`timescale 1ns/1ps
module ucil_host_model (
  input wire logic pclk,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ================================================================
  // Idle bus at time zero.
  initial
  begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
  end

  // One transfer; the request is held until pready is seen high, so a
  // slow slave is handled without assuming any latency.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // ucil_host_model

/* File: test/tb_top.sv */
// Self-checking testbench for the channel interrupt logic.
`timescale 1ns/1ps
module tb_top;
  import ucil_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic irq, irq_oe_n, cts;
  logic [7:0] paddr, glob, q;
  logic [31:0] pwdata, prdata;
  ucil_rx_s rx;
  ucil_tx_s tx;
  ucil_modem_s md;
  ucil_cfg_s cfg;
  ucil_strobe_s stb;
  int n_mismatch, comparisons, cyc;

  // ================================================================
  // Design, host model, clock and a hang limit.
  ucil_channel i_ucil_channel (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_i(rx), .tx_i(tx), .modem_i(md), .cts_pin(cts), .dsr_pin(1'b0),
    .cfg_o(cfg), .strobe_o(stb), .irq_o(irq), .irq_oe_n(irq_oe_n),
    .global_channel_irq_status(glob));
  ucil_host_model i_ucil_host_model (.pclk(pclk), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // A run of tens of thousands of cycles means a stuck handshake.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ================================================================
  // Shared helpers.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_ucil_host_model.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    i_ucil_host_model.xfer(1'b0, a, 8'h00, q, e);
    chk(q, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ================================================================
  // Scenarios.
  task automatic t_reset();
    rdc(8'h04, 8'h00);
    rdc(8'h08, 8'h01);
    chk(glob, 8'h01);
    chk({7'h00, irq_oe_n}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    rdc(8'h0c, 8'h00);
    chk({7'h00, e}, 8'h01);
    wr(8'h04, 8'hff);
    rdc(8'h04, 8'h0f);
    wr(8'h24, 8'h10);
    wr(8'h04, 8'hff);
    rdc(8'h04, 8'he0 | 8'h0f);
    wr(8'h04, 8'h00);
    $display("reset and mask test done");
  endtask
  task automatic t_rx_line();
    wr(8'h08, 8'h01);
    wr(8'h2c, 8'h04);
    rx.level <= 8'h01;
    rx.fifo_empty <= 1'b0;
    rx.char_stored <= 1'b1;
    tick(1);
    rx.char_stored <= 1'b0;
    chk(cfg.rx_trigger_level, 8'h04);
    chk({7'h00, cfg.fifo_en}, 8'h01);
    rdc(8'h14, 8'h01);
    chk({7'h00, irq_oe_n}, 8'h01);
    wr(8'h04, 8'h07);
    rx.level <= 8'h04;
    tick(3);
    chk({7'h00, irq_oe_n}, 8'h00);
    chk(glob, 8'h44);
    rdc(8'h08, 8'hc4);
    rx.overrun <= 1'b1;
    tick(1);
    rx.overrun <= 1'b0;
    rdc(8'h08, 8'hc4);
    rx.level <= 8'h03;
    rdc(8'h08, 8'hc6);
    rx.head_err <= 3'h5;
    rx.any_err <= 1'b1;
    tx.holding_empty <= 1'b1;
    tx.all_empty <= 1'b1;
    rdc(8'h14, 8'hf7);
    rdc(8'h08, 8'hc1);
    $display("receive and line status test done");
  endtask
  task automatic t_timeout();
    rx.level <= 8'h01;
    wr(8'h04, 8'h01);
    // One bit time short of four characters plus twelve bits.
    repeat (43)
    begin
      rx.bit_tick <= 1'b1;
      tick(1);
      rx.bit_tick <= 1'b0;
      tick(1);
    end
    rdc(8'h08, 8'hc1);
    rx.bit_tick <= 1'b1;
    tick(1);
    rx.bit_tick <= 1'b0;
    tick(1);
    rdc(8'h08, 8'hcc);
    rdc(8'h00, 8'h5a);
    @(negedge pclk);
    chk({7'h00, stb.rx_pop}, 8'h01);
    rdc(8'h08, 8'hc1);
    $display("timeout test done");
  endtask
  task automatic t_others();
    wr(8'h04, 8'h02);
    tx.below_trig <= 1'b1;
    tick(1);
    rdc(8'h08, 8'hc2);
    rdc(8'h08, 8'hc1);
    // Half-duplex mode: only the shifter going empty may count.
    tx.below_trig <= 1'b0;
    tx.rs485_auto <= 1'b1;
    tx.all_empty <= 1'b0;
    tick(1);
    tx.all_empty <= 1'b1;
    tick(3);
    chk({7'h00, irq_oe_n}, 8'h00);
    wr(8'h00, 8'h3c);
    @(negedge pclk);
    chk({7'h00, stb.tx_push}, 8'h01);
    chk(stb.tx_data, 8'h3c);
    rdc(8'h08, 8'hc1);
    wr(8'h04, 8'h08);
    md.delta_evt <= 4'h2;
    tick(1);
    md.delta_evt <= 4'h0;
    rdc(8'h08, 8'hc0);
    rdc(8'h18, 8'h02);
    rdc(8'h08, 8'hc1);
    wr(8'h04, 8'h20);
    rx.xoff_det <= 1'b1;
    tick(1);
    rx.xoff_det <= 1'b0;
    rdc(8'h08, 8'hd0);
    rdc(8'h08, 8'hc1);
    rdc(8'h30, 8'h01);
    rdc(8'h30, 8'h00);
    wr(8'h24, 8'h50);
    wr(8'h04, 8'h40);
    md.rts_level <= 1'b1;
    tick(1);
    rdc(8'h08, 8'he0);
    wr(8'h24, 8'h10);
    rdc(8'h18, 8'h00);
    rdc(8'h08, 8'hc1);
    // The pin passes two synchroniser stages before its edge is seen.
    wr(8'h24, 8'h90);
    wr(8'h04, 8'h80);
    cts <= 1'b1;
    tick(4);
    rdc(8'h08, 8'he0);
    rdc(8'h18, 8'h00);
    rdc(8'h08, 8'hc1);
    $display("transmit, modem and flow test done");
  endtask

  // ================================================================
  // Main sequence.
  initial
  begin
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    presetn = 1'b0;
    rx = '0;
    rx.fifo_empty = 1'b1;
    rx.char_bits = 4'h8;
    rx.data = 8'h5a;
    tx = '0;
    md = '0;
    cts = 1'b0;
    tick(6);
    presetn <= 1'b1;
    t_reset();
    t_rx_line();
    t_timeout();
    t_others();
    wrap_up();
  end
endmodule // tb_top
